// ---- design/cic_consts.svh ----
// Register offsets, field positions, reset values and constants.
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH
`define CIC_OFF_CTRL      8'h00
`define CIC_OFF_PEN1      8'h04
`define CIC_OFF_OPTION    8'h08
`define CIC_OFF_STATE     8'h0C
`define CIC_OFF_SH_ACC    8'h10
`define CIC_OFF_SH_STATUS 8'h14
`define CIC_OFF_SH_BANK   8'h18
`define CIC_OFF_SH_PTR0   8'h1C
`define CIC_OFF_SH_PTR1   8'h20
`define CIC_OFF_SH_PCH    8'h24
`define CIC_BIT_GLB_EN    7
`define CIC_BIT_PER_EN    6
`define CIC_BIT_T0IE      5
`define CIC_BIT_EXT_EN    4
`define CIC_BIT_CHG_EN    3
`define CIC_BIT_T0IF      2
`define CIC_BIT_EXT_FLAG  1
`define CIC_BIT_CHG_FLAG  0
`define CIC_BIT_EDGE_POL  0
`define CIC_CTRL_RST      8'h00
`define CIC_PEN1_RST      8'h00
`define CIC_OPTION_RST    8'h01
`define CIC_STATUS_SAVE   8'hE7
`define CIC_VECTOR        16'h0004
`endif

// ---- design/cic_core_irq_ctrl.sv ----
// Interrupt control with external edge pin, context shadows and AHB-Lite.
//
// Functional notes
// - External pin edge-triggered, polarity selectable.
// - Valid edge sets external edge flag.
// - Flag with both enables redirects to vector.
// - Entry pushes return address onto stack.
// - Entry copies context into shadows, status masked.
// - Return reloads context from shadows.
// - Shadows readable and writable by software.
// - Flags set regardless of any enable.
// - Global enable allows or blocks all requests.
// - Peripheral enable gates all peripheral requests.
// - Timer0 overflow sets flag; bit 5 enables.
// - External edge enable bit 4 gates request.
// - Pin-change flag reads pending changes; bit 0.
// - Pin-change flag read-only, clears with sources.
// - Peripheral enable register one bit layout.
// - Entry flushes, clears global enable, vectors 0004h.
// - Return pops, restores context, sets global enable.
// - Reset clears every enable bit.
`timescale 1ns/1ps
`include "cic_consts.svh"
`default_nettype none

module cic_core_irq_ctrl #(
   parameter int PC_W = 16                  // Program counter width.
) (
   input  wire logic              clock_in,        // 200 MHz clock.
   input  wire logic              srst_in,         // Sync reset, high.
   // AHB-Lite slave.
   input  wire logic              hsel_in,         // Slave select.
   input  wire logic [31:0]       haddr_in,        // Byte address.
   input  wire logic [1:0]        htrans_in,       // Transfer type.
   input  wire logic              hwrite_in,       // Write when high.
   input  wire logic [2:0]        hsize_in,        // Transfer size.
   input  wire logic              hready_in,       // Bus ready.
   input  wire logic [31:0]       hwdata_in,       // Write data.
   output var  logic [31:0]       hrdata_out,      // Read data.
   output var  logic              hreadyout_out,   // Slave ready.
   output var  logic              hresp_out,       // Always OKAY.
   // Interrupt sources.
   input  wire logic              ext_pin_in,      // Async edge pin.
   input  wire logic              timer0_ovf_in,   // Overflow pulse.
   input  wire logic              pin_change_in,   // Any change flag set.
   input  wire logic [7:0]        periph_flag_in,  // First flag group.
   // CPU sequencer.
   input  wire logic [PC_W-1:0]   pc_in,           // Return address.
   input  wire cic_pkg::cic_ctx_s ctx_in,          // Live context.
   input  wire logic              return_in,       // Return executed.
   output var  logic              irq_take_out,    // Entry pulse.
   output var  logic              flush_out,       // Flush prefetch.
   output var  logic [PC_W-1:0]   vector_out,      // Vector address.
   output var  logic              push_en_out,     // Stack push pulse.
   output var  logic [PC_W-1:0]   push_pc_out,     // Pushed address.
   output var  logic              pop_en_out,      // Stack pop pulse.
   output var  logic              restore_out,     // Context reload.
   output var  cic_pkg::cic_ctx_s ctx_out,         // Restored context.
   output var  logic              in_handler_out   // Handler active.
);

   generate
      if (PC_W < 3 || PC_W > 16) begin : g_bad_pc
         $error("PC_W must lie between 3 and 16.");
      end
   endgenerate

   localparam logic [2:0] SIZE_WORD = 3'h2;

   logic [7:0]        ctrl_reg;
   logic [7:0]        pen1_reg;
   logic [7:0]        option_reg;
   cic_pkg::cic_ctx_s shadow_reg;
   logic              sync1_reg;
   logic              sync2_reg;
   logic              pin_prev_reg;
   logic              handler_reg;
   cic_pkg::cic_ahb_req_s dph_reg;
   logic              dph_valid_reg;
   logic              rd_wait_reg;

   // Word-aligned register select from a byte offset.
   function automatic logic is_off(input logic [7:0] a,
                                   input logic [7:0] off);
      is_off = (a == off);
   endfunction : is_off

   // Read mux shared by the bus read path.
   function automatic logic [31:0] rd_mux(
      input logic [7:0]        a,
      input logic [7:0]        ctrl,
      input logic [7:0]        pen1,
      input logic [7:0]        opt,
      input logic              hnd,
      input cic_pkg::cic_ctx_s sh);
      rd_mux = 32'h0000_0000;
      case (a)
         `CIC_OFF_CTRL:      rd_mux = {24'h00_0000, ctrl};
         `CIC_OFF_PEN1:      rd_mux = {24'h00_0000, pen1};
         `CIC_OFF_OPTION:    rd_mux = {24'h00_0000, opt};
         `CIC_OFF_STATE:     rd_mux = {31'h0000_0000, hnd};
         `CIC_OFF_SH_ACC:    rd_mux = {24'h00_0000, sh.acc};
         `CIC_OFF_SH_STATUS: rd_mux = {24'h00_0000, sh.status};
         `CIC_OFF_SH_BANK:   rd_mux = {24'h00_0000, sh.bank_sel};
         `CIC_OFF_SH_PTR0:   rd_mux = {16'h0000, sh.ptr0};
         `CIC_OFF_SH_PTR1:   rd_mux = {16'h0000, sh.ptr1};
         `CIC_OFF_SH_PCH:    rd_mux = {24'h00_0000, sh.pc_high};
         default:            rd_mux = 32'h0000_0000;
      endcase
   endfunction : rd_mux

   // ---------------- Bus slave ----------------

   logic addr_ok;
   logic wr_now;
   logic [7:0] wr_addr;

   assign addr_ok = hsel_in && htrans_in[1] && hready_in
                    && (hsize_in == SIZE_WORD);
   assign wr_now  = dph_valid_reg && dph_reg.hwrite;
   assign wr_addr = dph_reg.addr;

   // Reads take one wait state so a write just before is seen.
   assign hreadyout_out = !(dph_valid_reg && !dph_reg.hwrite
                            && rd_wait_reg);
   assign hresp_out     = 1'b0;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         dph_valid_reg <= 1'b0;
         dph_reg       <= '0;
      end else if (hreadyout_out) begin
         dph_valid_reg <= addr_ok;
         dph_reg       <= '{htrans: htrans_in, hwrite: hwrite_in,
                            hsize: hsize_in, addr: haddr_in[7:0]};
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rd_wait_reg <= 1'b0;
      end else if (hreadyout_out) begin
         rd_wait_reg <= addr_ok && !hwrite_in;
      end else begin
         rd_wait_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (dph_valid_reg && !dph_reg.hwrite && rd_wait_reg) begin
         hrdata_out <= rd_mux(dph_reg.addr, ctrl_reg, pen1_reg,
                              option_reg, handler_reg, shadow_reg);
      end
   end

   // ---------------- External edge pin ----------------

   logic edge_seen;
   logic rise;
   logic fall;

   // Only the second stage feeds the edge detector, because the first
   // may still be settling from a metastable sample of the pin.
   // two-stage synchroniser
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sync1_reg    <= 1'b0;
         sync2_reg    <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         sync1_reg    <= ext_pin_in;
         sync2_reg    <= sync1_reg;
         pin_prev_reg <= sync2_reg;
      end
   end

   assign rise = sync2_reg && !pin_prev_reg;
   assign fall = !sync2_reg && pin_prev_reg;
   assign edge_seen = option_reg[`CIC_BIT_EDGE_POL] ? rise : fall;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         option_reg <= `CIC_OPTION_RST;
      end else if (wr_now && is_off(wr_addr, `CIC_OFF_OPTION)) begin
         option_reg <= {7'h00, hwdata_in[`CIC_BIT_EDGE_POL]};
      end
   end

   // ---------------- Request and entry ----------------

   logic periph_req;
   logic pending;
   logic take;
   logic wr_ctrl;

   assign periph_req = ctrl_reg[`CIC_BIT_PER_EN]
                       && |(pen1_reg & periph_flag_in);
   assign pending = (ctrl_reg[`CIC_BIT_T0IE] && ctrl_reg[`CIC_BIT_T0IF])
                 || (ctrl_reg[`CIC_BIT_EXT_EN]
                     && ctrl_reg[`CIC_BIT_EXT_FLAG])
                 || (ctrl_reg[`CIC_BIT_CHG_EN] && pin_change_in)
                 || periph_req;
   // A request blocked by the global enable stays in its flag, so it is
   // served as soon as software or a return sets the enable again.
   // global enable gates everything
   assign take = ctrl_reg[`CIC_BIT_GLB_EN] && pending;
   assign wr_ctrl = wr_now && is_off(wr_addr, `CIC_OFF_CTRL);

   // Hardware sets win over software clears on the flag bits.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_reg <= `CIC_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg[7:1] <= hwdata_in[7:1];
         end
         if (edge_seen) begin
            ctrl_reg[`CIC_BIT_EXT_FLAG] <= 1'b1;
         end
         if (timer0_ovf_in) begin
            ctrl_reg[`CIC_BIT_T0IF] <= 1'b1;
         end
         ctrl_reg[`CIC_BIT_CHG_FLAG] <= pin_change_in;
         if (return_in) begin
            ctrl_reg[`CIC_BIT_GLB_EN] <= 1'b1;
         end
         if (take) begin
            ctrl_reg[`CIC_BIT_GLB_EN] <= 1'b0;
         end
      end
   end

   // enable layout, bit 7 down to 0
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pen1_reg <= `CIC_PEN1_RST;
      end else if (wr_now && is_off(wr_addr, `CIC_OFF_PEN1)) begin
         pen1_reg <= hwdata_in[7:0];
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_take_out <= 1'b0;
         flush_out    <= 1'b0;
         vector_out   <= '0;
      end else begin
         irq_take_out <= take;
         flush_out    <= take;
         vector_out   <= take ? PC_W'(`CIC_VECTOR) : vector_out;
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         push_en_out <= 1'b0;
         push_pc_out <= '0;
      end else begin
         push_en_out <= take;
         if (take) begin
            push_pc_out <= pc_in;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         handler_reg <= 1'b0;
      end else if (take) begin
         handler_reg <= 1'b1;
      end else if (return_in) begin
         handler_reg <= 1'b0;
      end
   end

   assign in_handler_out = handler_reg;

   // ---------------- Shadow registers ----------------

   // Entry capture wins over a bus write in the same cycle.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         shadow_reg <= '0;
      end else if (take) begin
         shadow_reg        <= ctx_in;
         shadow_reg.status <= ctx_in.status & `CIC_STATUS_SAVE;
      end else if (wr_now) begin
         case (wr_addr)
            `CIC_OFF_SH_ACC:    shadow_reg.acc      <= hwdata_in[7:0];
            `CIC_OFF_SH_STATUS: shadow_reg.status   <= hwdata_in[7:0];
            `CIC_OFF_SH_BANK:   shadow_reg.bank_sel <= hwdata_in[7:0];
            `CIC_OFF_SH_PTR0:   shadow_reg.ptr0     <= hwdata_in[15:0];
            `CIC_OFF_SH_PTR1:   shadow_reg.ptr1     <= hwdata_in[15:0];
            `CIC_OFF_SH_PCH:    shadow_reg.pc_high  <= hwdata_in[7:0];
            default:            shadow_reg          <= shadow_reg;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pop_en_out  <= 1'b0;
         restore_out <= 1'b0;
         ctx_out     <= '0;
      end else begin
         pop_en_out  <= return_in;
         restore_out <= return_in;
         if (return_in) begin
            ctx_out <= shadow_reg;
         end
      end
   end

endmodule : cic_core_irq_ctrl

`default_nettype wire

// ---- design/cic_pkg.sv ----
// Types shared by the interrupt control block.
package cic_pkg;
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  status;
      logic [7:0]  bank_sel;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [7:0]  pc_high;
   } cic_ctx_s;
   typedef struct packed {
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [7:0]  addr;
   } cic_ahb_req_s;
endpackage : cic_pkg

// ---- testbench/cic_cpu_model.sv ----
// Behavioural CPU sequencer feeding live state and returning on request.
`timescale 1ns/1ps
`default_nettype none
module cic_cpu_model #(
   parameter int PC_W = 16                    // Counter width.
) (
   input  wire logic              clock_in,   // Clock.
   input  wire logic              srst_in,    // Reset.
   input  wire logic              ret_req_in, // Return request.
   input  wire logic              in_hnd_in,  // Handler active.
   output var  logic [PC_W-1:0]   pc_out,     // Running address.
   output var  cic_pkg::cic_ctx_s ctx_out,    // Live context.
   output var  logic              ret_out     // Return pulse.
);
   // State moves every cycle, so a capture on the wrong edge shows.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pc_out  <= '0;
         ctx_out <= 64'h0123_4567_89ab_cdef;
      end else begin
         pc_out  <= pc_out + 1'b1;
         ctx_out <= {ctx_out[62:0], ctx_out[63] ^ ctx_out[60]};
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in)
         ret_out <= 1'b0;
      else
         ret_out <= ret_req_in && in_hnd_in && !ret_out;
   end
endmodule : cic_cpu_model
`default_nettype wire

// ---- testbench/cic_monitor.sv ----
// Port assertions for the interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module cic_monitor #(
   parameter int PC_W = 16                 // Counter width.
) (
   input wire logic            clock_in,       // Clock.
   input wire logic            srst_in,        // Reset.
   input wire logic [PC_W-1:0] pc_in,          // Return address.
   input wire logic            return_in,      // Return pulse.
   input wire logic            hresp_out,      // Bus response.
   input wire logic            irq_take_out,   // Entry pulse.
   input wire logic            flush_out,      // Flush pulse.
   input wire logic [PC_W-1:0] vector_out,     // Vector.
   input wire logic            push_en_out,    // Push pulse.
   input wire logic [PC_W-1:0] push_pc_out,    // Pushed address.
   input wire logic            pop_en_out,     // Pop pulse.
   input wire logic            restore_out,    // Reload pulse.
   input wire logic            in_handler_out  // Handler active.
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   a_take_flush:
      assert property (irq_take_out |-> flush_out && push_en_out)
      else $error("entry without flush or push");
   a_take_single:
      assert property (irq_take_out |=> !irq_take_out)
      else $error("entry repeated");
   a_take_vector:
      assert property (irq_take_out |=> vector_out == PC_W'(4))
      else $error("wrong vector");
   a_push_addr:
      assert property (irq_take_out |-> push_pc_out == $past(pc_in))
      else $error("wrong pushed address");
   a_return_pop:
      assert property (return_in |=> pop_en_out && restore_out)
      else $error("return without pop");
   a_pop_leave:
      assert property (pop_en_out |-> restore_out && !in_handler_out)
      else $error("pop without reload");
   a_no_reentry:
      assert property ($past(in_handler_out) && in_handler_out
                       |-> !irq_take_out)
      else $error("entry inside handler");
   a_resp_okay:
      assert property (hresp_out == 1'b0)
      else $error("bad response");
   c_entry: cover property (irq_take_out);
   c_return: cover property (pop_en_out);
   c_trip: cover property (irq_take_out ##[1:400] pop_en_out);
endmodule : cic_monitor
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the interrupt control block.
`timescale 1ns/1ps
`include "cic_consts.svh"
`default_nettype none
module tb;
   localparam int PC_W = 16;
   logic              clock_in = 1'b0, srst_in = 1'b1;
   logic              hsel = 1'b0, hwrite = 1'b0, ext_pin = 1'b0;
   logic              t0_ovf = 1'b0, pin_chg = 1'b0, ret_req = 1'b0;
   logic [1:0]        htrans = 2'h0;
   logic [31:0]       haddr = '0, hwdata = '0, hrdata, rd_q;
   logic [7:0]        pflag = 8'h00;
   logic              hrdy, hresp, ret, take, flush, push, pop, rest, hnd;
   logic [PC_W-1:0]   pc, vec, push_pc;
   cic_pkg::cic_ctx_s ctx, ctx_o, prev_ctx, cap;
   int                num_errors = 0, num_checks = 0, takes = 0, pops = 0;
   always #2.5 clock_in = ~clock_in;
   cic_core_irq_ctrl #(.PC_W(PC_W)) u_dut (
      .clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .ext_pin_in(ext_pin), .timer0_ovf_in(t0_ovf),
      .pin_change_in(pin_chg), .periph_flag_in(pflag), .pc_in(pc),
      .ctx_in(ctx), .return_in(ret), .irq_take_out(take),
      .flush_out(flush), .vector_out(vec), .push_en_out(push),
      .push_pc_out(push_pc), .pop_en_out(pop), .restore_out(rest),
      .ctx_out(ctx_o), .in_handler_out(hnd));
   cic_cpu_model #(.PC_W(PC_W)) u_cpu (
      .clock_in(clock_in), .srst_in(srst_in), .ret_req_in(ret_req),
      .in_hnd_in(hnd), .pc_out(pc), .ctx_out(ctx), .ret_out(ret));
   always @(posedge clock_in) begin
      prev_ctx <= ctx;
      if (take === 1'b1) begin
         takes <= takes + 1;
         cap   <= prev_ctx;
      end
      if (pop === 1'b1)
         pops <= pops + 1;
   end
   task automatic finish_test;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [63:0] e, g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic chk_rd(input string n, input logic [31:0] e);
      chk(n, {32'h0, e}, {32'h0, rd_q});
   endtask : chk_rd
   // Values are looked at before the edge that samples them.
   task automatic wait_ev(ref logic s, input int lim);
      int n;
      for (n = 0; n < lim && s !== 1'b1; n++)
         @(negedge clock_in);
      if (n == lim) begin
         num_errors++;
         finish_test();
      end
   endtask : wait_ev
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      @(negedge clock_in);
      wait_ev(hrdy, 40);
      @(posedge clock_in);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(negedge clock_in);
      wait_ev(hrdy, 40);
      rd_q = hrdata;
      @(posedge clock_in);
   endtask : bus
   task automatic wait_cnt(ref int c, input int want);
      logic hit;
      hit = 1'b0;
      repeat (60) begin
         @(negedge clock_in);
         hit = hit | (c >= want);
      end
      chk("event", 64'h1, {63'h0, hit});
   endtask : wait_cnt
   function automatic cic_pkg::cic_ctx_s exp_ctx(input cic_pkg::cic_ctx_s c,
                                                 input logic [7:0] a);
      exp_ctx        = c;
      exp_ctx.acc    = a;
      exp_ctx.status = c.status & `CIC_STATUS_SAVE;
   endfunction : exp_ctx
   function automatic logic [7:0] en_of(input int k);
      return k == 0 ? 8'h10 : k == 1 ? 8'h20 : k == 2 ? 8'h08 : 8'h00;
   endfunction : en_of
   initial begin
      logic [31:0] v;
      logic [7:0]  m;
      void'($urandom(32'he65a));
      repeat (2) @(posedge clock_in);
      srst_in <= 1'b0;
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("ctrl", 32'h0);
      bus(`CIC_OFF_PEN1, 1'b0, 32'h0);
      chk_rd("pen1", 32'h0);
      bus(8'h40, 1'b1, 32'hffff_ffff);
      bus(8'h40, 1'b0, 32'h0);
      chk_rd("unmapped", 32'h0);
      repeat (3) begin
         v = $urandom;
         bus(`CIC_OFF_PEN1, 1'b1, v);
         bus(`CIC_OFF_PEN1, 1'b0, 32'h0);
         chk_rd("pen1", {24'h00_0000, v[7:0]});
      end
      t0_ovf  <= 1'b1;
      ext_pin <= 1'b1;
      pin_chg <= 1'b1;
      @(posedge clock_in);
      t0_ovf  <= 1'b0;
      repeat (6) @(posedge clock_in);
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("flags", 32'h7);
      bus(`CIC_OFF_CTRL, 1'b1, 32'h0);
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("ioc_ro", 32'h1);
      pin_chg <= 1'b0;
      bus(`CIC_OFF_OPTION, 1'b1, 32'h0);
      bus(`CIC_OFF_CTRL, 1'b1, 32'h0);
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("ioc_clr", 32'h0);
      ext_pin <= 1'b0;
      repeat (6) @(posedge clock_in);
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("fall", 32'h2);
      bus(`CIC_OFF_CTRL, 1'b1, 32'h0);
      ext_pin <= 1'b1;
      repeat (6) @(posedge clock_in);
      bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
      chk_rd("rise", 32'h0);
      bus(`CIC_OFF_OPTION, 1'b1, 32'h1);
      ext_pin <= 1'b0;
      chk("no_take", 64'h0, 64'(takes));
      for (int k = 0; k < 4; k++) begin
         v = $urandom;
         m = 8'h01 << v[10:8];
         bus(`CIC_OFF_CTRL, 1'b1, 32'h0);
         bus(`CIC_OFF_PEN1, 1'b1, {24'h00_0000, m});
         bus(`CIC_OFF_CTRL, 1'b1, {24'h00_0000, en_of(k)});
         ext_pin <= (k == 0);
         t0_ovf  <= (k == 1);
         pin_chg <= (k == 2);
         pflag   <= (k == 3) ? m : 8'h00;
         @(posedge clock_in);
         t0_ovf  <= 1'b0;
         repeat (8) @(posedge clock_in);
         chk("gated", 64'(k), 64'(takes));
         // Read back first so that the pending flag survives the write.
         bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
         if (k == 0)
            chk("edge_flag", 64'h1, {63'h0, rd_q[1]});
         bus(`CIC_OFF_CTRL, 1'b1, rd_q | 32'h80);
         repeat (8) @(posedge clock_in);
         if (k == 3) begin
            chk("per_gate", 64'h3, 64'(takes));
            bus(`CIC_OFF_CTRL, 1'b1, {24'h00_0000, en_of(k) | 8'hc0});
         end
         wait_cnt(takes, k + 1);
         bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
         chk("glb_off", 64'h0, {63'h0, rd_q[7]});
         bus(`CIC_OFF_SH_STATUS, 1'b0, 32'h0);
         chk_rd("sh_status", {24'h00_0000, exp_ctx(cap, 8'h0).status});
         bus(`CIC_OFF_SH_ACC, 1'b1, v);
         ext_pin <= 1'b0;
         pin_chg <= 1'b0;
         pflag   <= 8'h00;
         bus(`CIC_OFF_CTRL, 1'b1, 32'h0);
         ret_req <= 1'b1;
         @(posedge clock_in);
         ret_req <= 1'b0;
         wait_cnt(pops, k + 1);
         chk("ctx", exp_ctx(cap, v[7:0]), ctx_o);
         bus(`CIC_OFF_CTRL, 1'b0, 32'h0);
         chk_rd("glb_on", 32'h80);
      end
      finish_test();
   end
endmodule : tb
bind cic_core_irq_ctrl cic_monitor #(.PC_W(PC_W)) u_mon (
   .clock_in(clock_in), .srst_in(srst_in), .pc_in(pc_in),
   .return_in(return_in), .hresp_out(hresp_out),
   .irq_take_out(irq_take_out), .flush_out(flush_out),
   .vector_out(vector_out), .push_en_out(push_en_out),
   .push_pc_out(push_pc_out), .pop_en_out(pop_en_out),
   .restore_out(restore_out), .in_handler_out(in_handler_out));
`default_nettype wire
